// File: src/pcfg_pkg.sv
// Notes on behaviour
// [RQ1] pin7 field: 00 pull-up input, 01 plain input, 10 output, 11 analog ch7
// [RQ2] pin6 field: 00 pull-up input, 01 pwm output, 10 output, 11 analog ch6
// [RQ3] pin6 code 11 routes pin to analog ch6 and kills digital input
// [RQ4] pin5 field in high bits 3:2 decodes pull-up, plain, output, analog
// [RQ5] pin4 field in high bits 1:0 decodes pull-up, plain, output, analog
// [RQ6] pin3 field in low bits 7:6: plain, pull-up, output, analog
// [RQ7] pin2 field in low bits 5:4: plain, pull-up, output, analog
// [RQ8] pin1 field in low bits 3:2: plain, pull-up, output, analog
// [RQ9] pin1 code 00 is plain input and falling-edge interrupt 1 source
// [RQ10] pin1 code 01 enables pull-up and stays falling-edge interrupt 1 source
// [RQ11] low config register resets to zero, all bits read and write
// [RQ12] falling-edge interrupt 1 is gated by an enable bit
package pcfg_pkg;
  // word byte addresses on the wishbone bus
  // five address bits so the mask register at 0x10 does not alias config_high
  localparam logic [4:0] ADDR_CFG_HIGH = 5'h00;
  localparam logic [4:0] ADDR_CFG_LOW  = 5'h04;
  localparam logic [4:0] ADDR_INT_EN   = 5'h08;
  localparam logic [4:0] ADDR_INT_STAT = 5'h0c;
  localparam logic [4:0] ADDR_INT_MASK = 5'h10;
  localparam logic [7:0] CFG_LOW_OFFSET = 8'he7; // printed register offset
  localparam logic [7:0] RST_CFG_HIGH = 8'h00;
  localparam logic [7:0] RST_CFG_LOW  = 8'h00;
  localparam int EN_BIT = 3;
  localparam int STAT_BIT = 0;
  // mode codes
  localparam logic [1:0] M_IN_A  = 2'h0;
  localparam logic [1:0] M_IN_B  = 2'h1;
  localparam logic [1:0] M_OUT   = 2'h2;
  localparam logic [1:0] M_ANA   = 2'h3;
  localparam int NPIN = 7; // pins 1..7 as index 0..6
endpackage : pcfg_pkg

// File: src/pcfg_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pcfg_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_q, s2_q, s3_q;

  ////////////////////////////////////////////////////////////////
  // stages reset high so idle pulled-up pins do not fake an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filtered level only follows a settled change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b1;
    end else if (s2_q == s3_q) begin
      q_o <= s3_q;
    end
  end
endmodule : pcfg_sync

// File: src/pcfg_port0.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// port 0 pin configuration, pins 1 to 7, classic wishbone slave
module pcfg_port0 (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  input  wire logic       we_i,
  input  wire logic [3:0] sel_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  output logic            ack_o,
  input  wire logic [6:0] pin_in_i,
  input  wire logic [6:0] pin_out_val_i,
  input  wire logic       pwm_i,
  output logic [6:0]      pin_out_o,
  output logic [6:0]      pin_oe_n_o,
  output logic [6:0]      pin_pullup_o,
  output logic [6:0]      schmitt_en_o,
  output logic [6:0]      analog_sel_o,
  output logic [6:0]      pin_data_o,
  output logic            irq_o
);
  logic [7:0] cfg_high_q;
  logic [7:0] cfg_low_q;
  logic       int_en_q;
  logic       stat_q;
  logic       mask_q;
  logic [1:0] mode [pcfg_pkg::NPIN];
  logic [6:0] pin_sync;
  logic       pin1_prev_q;
  logic       fall_evt;
  logic       wr_stb;
  logic       rd_stb;
  logic [31:0] rd_d;

  ////////////////////////////////////////////////////////////////
  // bus strobes: one-cycle ack, valid only on a fresh request
  assign wr_stb = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  assign rd_stb = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= rd_stb;
    end
  end

  // configuration registers, byte lane 0 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_high_q <= pcfg_pkg::RST_CFG_HIGH;
      cfg_low_q  <= pcfg_pkg::RST_CFG_LOW; // RQ11
      int_en_q   <= 1'b0;
      mask_q     <= 1'b0;
    end else if (wr_stb) begin
      if (adr_i == pcfg_pkg::ADDR_CFG_HIGH) begin
        cfg_high_q <= dat_i[7:0];
      end
      if (adr_i == pcfg_pkg::ADDR_CFG_LOW) begin
        cfg_low_q <= dat_i[7:0]; // RQ11
      end
      if (adr_i == pcfg_pkg::ADDR_INT_EN) begin
        int_en_q <= dat_i[pcfg_pkg::EN_BIT];
      end
      if (adr_i == pcfg_pkg::ADDR_INT_MASK) begin
        mask_q <= dat_i[pcfg_pkg::STAT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // field map: high holds pins 7..4, low holds pins 3..1
  assign mode[6] = cfg_high_q[7:6]; // RQ1
  assign mode[5] = cfg_high_q[5:4]; // RQ2
  assign mode[4] = cfg_high_q[3:2]; // RQ4
  assign mode[3] = cfg_high_q[1:0]; // RQ5
  assign mode[2] = cfg_low_q[7:6];  // RQ6
  assign mode[1] = cfg_low_q[5:4];  // RQ7
  assign mode[0] = cfg_low_q[3:2];  // RQ8

  // per-pin decode; low-register pins swap the meaning of 00 and 01
  for (genvar i = 0; i < pcfg_pkg::NPIN; i++) begin : g_pin
    localparam bit LOW_REG = (i < 3);
    pcfg_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pin_in_i[i]),
      .q_o   (pin_sync[i])
    );
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_out_o[i]    <= 1'b0;
        pin_oe_n_o[i]   <= 1'b1;
        pin_pullup_o[i] <= 1'b0;
        schmitt_en_o[i] <= 1'b1;
        analog_sel_o[i] <= 1'b0;
        pin_data_o[i]   <= 1'b0;
      end else begin
        pin_out_o[i]    <= pin_out_val_i[i];
        pin_oe_n_o[i]   <= !(mode[i] == pcfg_pkg::M_OUT);
        pin_pullup_o[i] <= LOW_REG ? (mode[i] == pcfg_pkg::M_IN_B)
                                   : (mode[i] == pcfg_pkg::M_IN_A); // RQ10
        schmitt_en_o[i] <= (mode[i] != pcfg_pkg::M_ANA); // RQ3
        analog_sel_o[i] <= (mode[i] == pcfg_pkg::M_ANA); // RQ3
        pin_data_o[i]   <= (mode[i] == pcfg_pkg::M_ANA) ? 1'b0 : pin_sync[i];
        // pwm alternate function on pin6 overrides the output path
        if (i == 5 && mode[i] == pcfg_pkg::M_IN_B) begin
          pin_out_o[i]  <= pwm_i; // RQ2
          pin_oe_n_o[i] <= 1'b0;  // RQ2
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin1 falling edge only while in an input mode (00 or 01)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin1_prev_q <= 1'b1;
    end else begin
      pin1_prev_q <= pin_sync[0];
    end
  end

  assign fall_evt = pin1_prev_q && !pin_sync[0] && !mode[0][1] && int_en_q; // RQ9 RQ12

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 1'b0;
    end else if (fall_evt) begin
      stat_q <= 1'b1; // RQ9
    end else if (wr_stb && adr_i == pcfg_pkg::ADDR_INT_STAT && dat_i[pcfg_pkg::STAT_BIT]) begin
      stat_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= stat_q && mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (adr_i)
      pcfg_pkg::ADDR_CFG_HIGH: rd_d[7:0] = cfg_high_q;
      pcfg_pkg::ADDR_CFG_LOW:  rd_d[7:0] = cfg_low_q;
      pcfg_pkg::ADDR_INT_EN:   rd_d[pcfg_pkg::EN_BIT] = int_en_q;
      pcfg_pkg::ADDR_INT_STAT: rd_d[pcfg_pkg::STAT_BIT] = stat_q;
      pcfg_pkg::ADDR_INT_MASK: rd_d[pcfg_pkg::STAT_BIT] = mask_q;
      default:                 rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      dat_o <= rd_d;
    end
  end
endmodule : pcfg_port0

// File: dv/pcfg_assertions.sv
`timescale 1ns/1ps
module pcfg_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       irq_o,
  input wire logic [6:0] pin_oe_n_o,
  input wire logic [6:0] pin_pullup_o,
  input wire logic [6:0] schmitt_en_o,
  input wire logic [6:0] analog_sel_o,
  input wire logic [6:0] pin_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  AST_ACK_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  AST_RST: assert property ($fell(rst_i) |-> pin_oe_n_o == 7'h7f && analog_sel_o == 7'h00
    && pin_pullup_o[2:0] == 3'h0 && !irq_o) else $error("bad reset state");
  AST_ANA6: assert property (analog_sel_o[5] |-> !schmitt_en_o[5] && pin_oe_n_o[5]
    && !pin_data_o[5]) else $error("pin6 analog mode wrong");
  AST_EXCL: assert property ((~pin_oe_n_o & (analog_sel_o | pin_pullup_o)) == 7'h00)
    else $error("driven pin also analog or pulled up");
  AST_ANA_SCH: assert property ((analog_sel_o & schmitt_en_o) == 7'h00)
    else $error("schmitt on in analog mode");
  AST_DATA: assert property ((pin_data_o & analog_sel_o) == 7'h00)
    else $error("digital data in analog mode");
endmodule : pcfg_assertions
bind pcfg_port0 pcfg_assertions pcfg_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o), .pin_oe_n_o(pin_oe_n_o),
  .pin_pullup_o(pin_pullup_o), .schmitt_en_o(schmitt_en_o), .analog_sel_o(analog_sel_o),
  .pin_data_o(pin_data_o));

// File: dv/pcfg_board.sv
`timescale 1ns/1ps
// board side of the pins; an undriven pin without pull-up wanders every cycle
module pcfg_board (
  input  wire logic       clk_i,
  input  wire logic [6:0] drv_i,
  input  wire logic [6:0] oe_n_i,
  input  wire logic [6:0] pu_i,
  input  wire logic [6:0] ext_i,
  input  wire logic [6:0] ext_en_i,
  output logic [6:0]      lvl_o
);
  logic [6:0] flt_q = 7'h00;
  always @(posedge clk_i) flt_q <= ~flt_q;
  // design drive wins, then board drive, then pull-up, else floating
  assign lvl_o = ~oe_n_i & drv_i | oe_n_i & (ext_en_i & ext_i | ~ext_en_i & (pu_i | flt_q));
endmodule : pcfg_board

// File: dv/tb_pcfg_port0.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_pcfg_port0;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, irq_o;
  logic [4:0] adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [6:0] pin_in_i, pin_out_o, oe_n, pu, sch, ana, pdat, ext = 7'h55, ext_en = 7'h7f;
  logic [7:0] q, lo[5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h9c};
  logic [7:0] hi[5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'hd2};
  logic [6:0] epu[5] = '{7'h78, 7'h07, 7'h00, 7'h00, 7'h12};
  logic [6:0] eoe[5] = '{7'h7f, 7'h5f, 7'h00, 7'h7f, 7'h53};
  logic [6:0] ean[5] = '{7'h00, 7'h00, 7'h00, 7'h7f, 7'h41};
  int miscompares = 0, n_compared = 0;
  initial forever #5 clk_i = ~clk_i;
  pcfg_port0 pcfg_port0_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(4'h1), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .pin_in_i(pin_in_i), .pin_out_val_i(7'h2a), .pwm_i(1'b0), .pin_out_o(pin_out_o),
    .pin_oe_n_o(oe_n), .pin_pullup_o(pu), .schmitt_en_o(sch), .analog_sel_o(ana),
    .pin_data_o(pdat), .irq_o(irq_o));
  pcfg_board pcfg_board_inst (.clk_i(clk_i), .drv_i(pin_out_o), .oe_n_i(oe_n), .pu_i(pu),
    .ext_i(ext), .ext_en_i(ext_en), .lvl_o(pin_in_i));
  // one classic cycle; the wait is bounded so a dead slave cannot hang the run
  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    adr_i <= a; we_i <= w; dat_i <= {24'h0, d}; cyc_i <= 1; stb_i <= 1;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin miscompares++; tally_and_finish; end
    q = dat_o[7:0];
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic fall();
    ext[0] <= 1; repeat (8) @(posedge clk_i);
    ext[0] <= 0; repeat (8) @(posedge clk_i);
  endtask : fall
  task automatic tally_and_finish();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0; @(posedge clk_i);
    wb(pcfg_pkg::ADDR_CFG_LOW, 0, 8'h0); `CHK("cfg_low", 8'h00, q)
    wb(5'h02, 0, 8'h0); `CHK("unmapped", 8'h00, q)
    `CHK("pullup rst", 7'h78, pu)
    // every code on every field, then a mixed pattern to catch swapped fields
    for (int i = 0; i < 5; i++) begin
      wb(pcfg_pkg::ADDR_CFG_LOW, 1, lo[i]); wb(pcfg_pkg::ADDR_CFG_HIGH, 1, hi[i]);
      ext_en <= 7'h0f; repeat (8) @(posedge clk_i);
      `CHK("pullup", epu[i], pu)
      `CHK("oe_n", eoe[i], oe_n)
      `CHK("analog", ean[i], ana)
      `CHK("schmitt", 7'h00, sch & ana)
      `CHK("schmitt on", ~ean[i], sch)
      if (i == 0) `CHK("data", 7'h75, pdat)
      if (i == 1) `CHK("pwm", 1'b0, pin_out_o[5])
      if (i == 2) `CHK("drive", 7'h2a, pin_out_o)
      if (i == 3) `CHK("ana data", 7'h00, pdat)
      wb(pcfg_pkg::ADDR_CFG_LOW, 0, 8'h0); `CHK("cfg_low rb", lo[i], q)
      ext_en <= 7'h7f; $display("mode pattern %0d done", i);
    end
    wb(pcfg_pkg::ADDR_CFG_LOW, 1, 8'h00); wb(pcfg_pkg::ADDR_INT_EN, 1, 8'h08);
    wb(pcfg_pkg::ADDR_INT_MASK, 1, 8'h01); wb(pcfg_pkg::ADDR_INT_STAT, 1, 8'h01);
    fall(); `CHK("irq", 1'b1, irq_o)
    wb(pcfg_pkg::ADDR_INT_STAT, 0, 8'h0); `CHK("stat", 8'h01, q)
    wb(pcfg_pkg::ADDR_INT_STAT, 1, 8'h01); `CHK("irq clr", 1'b0, irq_o)
    wb(pcfg_pkg::ADDR_CFG_LOW, 1, 8'h04); fall();
    wb(pcfg_pkg::ADDR_INT_STAT, 0, 8'h0); `CHK("stat pu", 8'h01, q)
    wb(pcfg_pkg::ADDR_INT_STAT, 1, 8'h01); wb(pcfg_pkg::ADDR_INT_EN, 1, 8'h00); fall();
    wb(pcfg_pkg::ADDR_INT_STAT, 0, 8'h0); `CHK("stat off", 8'h00, q)
    $display("interrupt test done");
    tally_and_finish;
  end
endmodule : tb_pcfg_port0
